// File: hw/psc_ctrl.v
// What this block does
// - Power state changes only come from the wait instruction or a wake-up interrupt.
// - Fast RC run mode clocks the CPU from fast RC, optionally postscaled.
// - Low-power RC run mode clocks the CPU from the low-power RC.
// - Secondary oscillator run mode clocks the CPU from the secondary oscillator.
// - Peripheral bus clock is the system clock divided by a two-bit field.
// - Idle and Sleep both stop the CPU clock, with any clock source.
// - Primary oscillator Idle keeps the primary oscillator running as system clock.
// - In Idle, peripherals keep running on the system clock.
// - Fast RC Idle keeps system clock from fast RC, with or without postscaler.
// - Secondary oscillator Idle keeps system clock from the secondary oscillator.
// - Low-power RC Idle keeps system clock from the low-power RC.
// - Sleep stops CPU, system clock, its source (unless the watchdog or SOSCEN holds it on) and peripherals on that clock.
// - In Sleep, peripherals with dedicated clocks may keep running.
// - Registers have clear, set and invert aliases at +0x4, +0x8, +0xC.
// - Unlock key register has no aliases; only its base address is writable.
// - Unimplemented bits ignore writes and read as zero.
// - Reset values depend on configuration words and on the reset kind.
// - Sleep stops the fail-safe monitor and does not clear the watchdog.
`timescale 1ns/100ps
`include "psc_defs.vh"

module psc_ctrl #(
	parameter [31:0] KEY_FIRST  = 32'h1234_5678,
	parameter [31:0] KEY_SECOND = 32'h8765_4321
) (
	// Clock and reset
	input  wire        mclk_in,
	input  wire        reset_in,
	// APB slave
	input  wire        psel_in,
	input  wire        penable_in,
	input  wire        pwrite_in,
	input  wire [15:0] paddr_in,
	input  wire [31:0] pwdata_in,
	output reg  [31:0] prdata_out,
	output wire        pready_out,
	output wire        pslverr_out,
	// Configuration words and reset kind, sampled while reset is high
	input  wire [15:0] device_config_words_in,
	input  wire        por_event_in,
	input  wire        bor_event_in,
	input  wire        ext_reset_event_in,
	input  wire        wdt_timeout_event_in,
	input  wire        cfg_mismatch_in,
	// CPU side
	input  wire        wait_instr_in,
	input  wire        wake_irq_in,
	// Analog oscillator status pins
	input  wire        secondary_osc_ready_in,
	input  wire        pll_lock_in,
	input  wire        clk_fail_in,
	// Clock gating and oscillator control
	output reg         cpu_clk_en_out,
	output reg         system_clock_net_run_out,
	output reg         periph_clk_en_out,
	output reg         peripheral_bus_clock_en_out,
	output reg  [2:0]  sys_src_sel_out,
	output reg  [2:0]  frc_postscale_out,
	output reg         primary_osc_en_out,
	output reg         fast_internal_rc_osc_en_out,
	output reg         low_power_internal_rc_osc_en_out,
	output reg         secondary_osc_en_out,
	output reg         fail_safe_clock_monitor_en_out,
	output reg  [5:0]  osc_tune_out,
	output reg         watchdog_timer_en_out,
	output reg         watchdog_timer_clear_out,
	output reg         sw_reset_req_out,
	output reg  [1:0]  power_state_out
);

	// ----------------------------------------------------------------
	// Local codes
	// ----------------------------------------------------------------
	localparam [1:0] ST_RUN    = 2'h0;
	localparam [1:0] ST_IDLE   = 2'h1;
	localparam [1:0] ST_SLEEP  = 2'h2;
	localparam [1:0] LK_LOCKED = 2'h0;
	localparam [1:0] LK_HALF   = 2'h1;
	localparam [1:0] LK_OPEN   = 2'h2;

	// Apply a direct, clear, set or invert write through a field mask
	function [31:0] psc_apply;
		input [31:0] cur;
		input [31:0] wd;
		input [31:0] mask;
		input [1:0]  al;
		begin
			case (al)
				`PSC_AL_DIR: psc_apply = (cur & ~mask) | (wd & mask);
				`PSC_AL_CLR: psc_apply = cur & ~(wd & mask);
				`PSC_AL_SET: psc_apply = cur | (wd & mask);
				default:     psc_apply = cur ^ (wd & mask);
			endcase
		end
	endfunction

	// ----------------------------------------------------------------
	// State
	// ----------------------------------------------------------------
	reg  [31:0] osc_q, osc_d;
	reg  [2:0]  cosc_q, cosc_d;
	reg  [31:0] wdt_q, wdt_d;
	reg  [31:0] tun_q, tun_d;
	reg  [31:0] rcn_q, rcn_d;
	reg  [31:0] swr_q, swr_d;
	reg  [1:0]  lock_q, lock_d;
	reg  [1:0]  pst_q, pst_d;
	reg  [2:0]  pb_cnt_q;
	reg  [2:0]  sync1_q, sync2_q;
	reg  [31:0] rd_word;
	reg         wdt_clr_d;
	reg         swrst_d;

	wire        secondary_osc_rdy   = sync2_q[0];
	wire        pll_lock   = sync2_q[1];
	wire        clk_fail   = sync2_q[2];
	wire [1:0]  alias_sel  = paddr_in[3:2];
	wire [15:0] base       = {paddr_in[15:4], 4'h0};
	wire        aligned    = (paddr_in[1:0] == 2'h0);
	wire        hit_wdt    = aligned && (base == `PSC_WDT_OFS);
	wire        hit_osc    = aligned && (base == `PSC_OSC_OFS);
	wire        hit_tun    = aligned && (base == `PSC_TUN_OFS);
	wire        hit_rcn    = aligned && (base == `PSC_RCN_OFS);
	wire        hit_swr    = aligned && (base == `PSC_SWR_OFS);
	wire        hit_key    = (paddr_in == `PSC_KEY_OFS);
	wire        hit_any    = hit_wdt | hit_osc | hit_tun | hit_rcn | hit_swr | hit_key;
	wire        acc        = psel_in & penable_in;
	wire        wr_acc     = acc & pwrite_in;
	wire        rd_acc     = acc & ~pwrite_in;
	wire        unlocked   = (lock_q == LK_OPEN);
	wire        sys_run    = (pst_q != ST_SLEEP);
	wire [1:0]  pbdiv      = osc_q[`PSC_OSC_PBDIV +: 2];
	wire [2:0]  pb_top     = (3'h1 << pbdiv) - 3'h1;
	wire [2:0]  nosc       = osc_q[`PSC_OSC_NOSC +: 3];
	wire        sw_pending = osc_q[`PSC_OSC_OSWEN];

	// ----------------------------------------------------------------
	// APB answer: zero wait states, error on unmapped or misaligned
	// ----------------------------------------------------------------
	assign pready_out  = 1'b1;
	assign pslverr_out = acc & ~hit_any;

	// Read view; read-only fields are merged in, unused bits stay zero
	always @* begin
		rd_word = 32'h0000_0000;
		if (hit_osc) begin
			rd_word = osc_q & `PSC_OSC_WMASK;
			rd_word[`PSC_OSC_COSC +: 3] = cosc_q;
			rd_word[`PSC_OSC_SOSCRDY]   = secondary_osc_rdy;
			rd_word[`PSC_OSC_SLOCK]     = pll_lock;
		end else if (hit_wdt) begin
			rd_word = wdt_q & (`PSC_WDT_WMASK | 32'h0000_007C);
		end else if (hit_tun) begin
			rd_word = tun_q & `PSC_TUN_WMASK;
		end else if (hit_rcn) begin
			rd_word = rcn_q & `PSC_RCN_WMASK;
		end else if (hit_swr) begin
			rd_word = swr_q & `PSC_SWR_WMASK;
		end
	end

	// ----------------------------------------------------------------
	// Register next-state logic
	// ----------------------------------------------------------------
	// Hardware flag sets are applied after the software write so that a set wins
	always @* begin
		osc_d     = osc_q;
		cosc_d    = cosc_q;
		wdt_d     = wdt_q;
		tun_d     = tun_q;
		rcn_d     = rcn_q;
		swr_d     = swr_q;
		lock_d    = lock_q;
		pst_d     = pst_q;
		wdt_clr_d = 1'b0;
		swrst_d   = 1'b0;
		// Clock switch completes once the target is usable
		if (sw_pending && (nosc != `PSC_SRC_SECONDARY_OSC || secondary_osc_rdy)) begin
			cosc_d = nosc;
			osc_d[`PSC_OSC_OSWEN] = 1'b0;
		end
		if (wr_acc && hit_osc) begin
			osc_d = psc_apply(osc_d, pwdata_in, `PSC_OSC_WMASK, alias_sel);
			// Source switching needs the unlock sequence and no clock lock
			if (!unlocked || osc_q[`PSC_OSC_CLKLOCK]) begin
				osc_d = (osc_d & ~`PSC_OSC_PROT) | (osc_q & `PSC_OSC_PROT);
			end
		end
		if (wr_acc && hit_wdt) begin
			wdt_d = psc_apply(wdt_q, pwdata_in, `PSC_WDT_WMASK, alias_sel);
			wdt_clr_d = wdt_d[`PSC_WDT_CLR];
			wdt_d[`PSC_WDT_CLR] = 1'b0;
		end
		if (wr_acc && hit_tun) begin
			tun_d = psc_apply(tun_q, pwdata_in, `PSC_TUN_WMASK, alias_sel);
		end
		if (wr_acc && hit_rcn) begin
			rcn_d = psc_apply(rcn_q, pwdata_in, `PSC_RCN_WMASK, alias_sel);
		end
		if (wr_acc && hit_swr && unlocked) begin
			swr_d = psc_apply(swr_q, pwdata_in, `PSC_SWR_WMASK, alias_sel);
		end
		// Reading the trigger register with the arm bit set fires the reset
		if (rd_acc && hit_swr && swr_q[0]) begin
			swrst_d  = 1'b1;
			swr_d[0] = 1'b0;
		end
		// Unlock sequence: two exact key words back to back
		if (wr_acc && hit_key) begin
			if (pwdata_in == KEY_FIRST) begin
				lock_d = LK_HALF;
			end else if (pwdata_in == KEY_SECOND && lock_q == LK_HALF) begin
				lock_d = LK_OPEN;
			end else begin
				lock_d = LK_LOCKED;
			end
		end
		// Fail-safe monitor reports only while the system clock runs
		if (clk_fail && sys_run) begin
			osc_d[`PSC_OSC_CF] = 1'b1;
		end
		// Power state machine driven by the wait instruction and wake-up
		case (pst_q)
			ST_RUN: begin
				if (wait_instr_in) begin
					pst_d = osc_q[`PSC_OSC_SLEEP_SELECT_BIT] ? ST_SLEEP : ST_IDLE;
				end
			end
			ST_IDLE: begin
				if (wake_irq_in) begin
					pst_d = ST_RUN;
					rcn_d[`PSC_RCN_IDLE] = 1'b1;
				end
			end
			ST_SLEEP: begin
				if (wake_irq_in) begin
					pst_d = ST_RUN;
					rcn_d[`PSC_RCN_SLEEP] = 1'b1;
				end
			end
			default: begin
				pst_d = ST_RUN;
			end
		endcase
	end

	// ----------------------------------------------------------------
	// Registers
	// ----------------------------------------------------------------
	// Reset loads configuration words and keeps cause flags, other than the mismatch flag, unless power-on
	always @(posedge mclk_in) begin
		if (reset_in) begin
			osc_q  <= `PSC_RST_VALUE;
			osc_q[`PSC_OSC_NOSC +: 3]   <= device_config_words_in[`PSC_CFG_OSC +: 3];
			osc_q[`PSC_OSC_FRCDIV +: 3] <= device_config_words_in[`PSC_CFG_FRCDIV +: 3];
			osc_q[`PSC_OSC_PBDIV +: 2]  <= device_config_words_in[`PSC_CFG_PBDIV +: 2];
			osc_q[`PSC_OSC_SOSCEN]      <= device_config_words_in[`PSC_CFG_SOSCEN];
			cosc_q <= device_config_words_in[`PSC_CFG_OSC +: 3];
			wdt_q  <= `PSC_RST_VALUE;
			wdt_q[`PSC_WDT_ON]       <= device_config_words_in[`PSC_CFG_WDTEN];
			wdt_q[`PSC_WDT_PS +: 5]  <= device_config_words_in[`PSC_CFG_WDTPS +: 5];
			tun_q  <= `PSC_RST_VALUE;
			swr_q  <= `PSC_RST_VALUE;
			lock_q <= LK_LOCKED;
			pst_q  <= ST_RUN;
			if (por_event_in) begin
				rcn_q <= `PSC_RST_VALUE;
				rcn_q[`PSC_RCN_POR] <= 1'b1;
			end else begin
				rcn_q[`PSC_RCN_BOR]  <= rcn_q[`PSC_RCN_BOR] | bor_event_in;
				rcn_q[`PSC_RCN_EXTR] <= rcn_q[`PSC_RCN_EXTR] | ext_reset_event_in;
				rcn_q[`PSC_RCN_WDTO] <= rcn_q[`PSC_RCN_WDTO] | wdt_timeout_event_in;
				rcn_q[`PSC_RCN_SWR]  <= rcn_q[`PSC_RCN_SWR] | sw_reset_req_out;
			end
			rcn_q[`PSC_RCN_CMR] <= cfg_mismatch_in;
		end else begin
			osc_q  <= osc_d;
			cosc_q <= cosc_d;
			wdt_q  <= wdt_d;
			tun_q  <= tun_d;
			rcn_q  <= rcn_d;
			swr_q  <= swr_d;
			lock_q <= lock_d;
			pst_q  <= pst_d;
		end
	end

	// Two-flop synchronisers for the analog oscillator status pins
	always @(posedge mclk_in) begin
		if (reset_in) begin
			sync1_q <= 3'h0;
			sync2_q <= 3'h0;
		end else begin
			sync1_q <= {clk_fail_in, pll_lock_in, secondary_osc_ready_in};
			sync2_q <= sync1_q;
		end
	end

	// Read data is captured in the setup cycle, valid through the access
	always @(posedge mclk_in) begin
		if (reset_in) begin
			prdata_out <= 32'h0000_0000;
		end else if (psel_in && !penable_in && !pwrite_in) begin
			prdata_out <= rd_word;
		end
	end

	// ----------------------------------------------------------------
	// Peripheral bus clock divider
	// ----------------------------------------------------------------
	// Counts only while the system clock runs, so Sleep freezes it
	always @(posedge mclk_in) begin
		if (reset_in) begin
			pb_cnt_q <= 3'h0;
			peripheral_bus_clock_en_out <= 1'b0;
		end else if (sys_run) begin
			peripheral_bus_clock_en_out <= (pb_cnt_q == 3'h0);
			pb_cnt_q <= (pb_cnt_q >= pb_top) ? 3'h0 : pb_cnt_q + 3'h1;
		end else begin
			peripheral_bus_clock_en_out <= 1'b0;
		end
	end

	// ----------------------------------------------------------------
	// Clock gating and oscillator enables
	// ----------------------------------------------------------------
	// The selected source stays on in Idle; only Sleep drops it
	always @(posedge mclk_in) begin
		if (reset_in) begin
			cpu_clk_en_out                   <= 1'b0;
			system_clock_net_run_out         <= 1'b0;
			periph_clk_en_out                <= 1'b0;
			sys_src_sel_out                  <= `PSC_SRC_FRC;
			frc_postscale_out                <= 3'h0;
			primary_osc_en_out               <= 1'b0;
			fast_internal_rc_osc_en_out      <= 1'b0;
			low_power_internal_rc_osc_en_out <= 1'b0;
			secondary_osc_en_out             <= 1'b0;
			fail_safe_clock_monitor_en_out   <= 1'b0;
			osc_tune_out                     <= 6'h00;
			watchdog_timer_en_out            <= 1'b0;
			watchdog_timer_clear_out         <= 1'b0;
			sw_reset_req_out                 <= 1'b0;
			power_state_out                  <= ST_RUN;
		end else begin
			cpu_clk_en_out           <= (pst_q == ST_RUN);
			system_clock_net_run_out <= sys_run;
			periph_clk_en_out        <= sys_run;
			sys_src_sel_out          <= cosc_q;
			frc_postscale_out <= (cosc_q == `PSC_SRC_FRCDIV) ?
				osc_q[`PSC_OSC_FRCDIV +: 3] : 3'h0;
			primary_osc_en_out <= (cosc_q == `PSC_SRC_PRIMARY_OSC) && sys_run;
			fast_internal_rc_osc_en_out <= ((cosc_q == `PSC_SRC_FRC) ||
				(cosc_q == `PSC_SRC_FRCDIV)) && sys_run;
			// Dedicated clock users keep the low-power and secondary sources
			low_power_internal_rc_osc_en_out <= ((cosc_q == `PSC_SRC_LOW_POWER_INTERNAL_RC_OSC) && sys_run) ||
				wdt_q[`PSC_WDT_ON];
			secondary_osc_en_out <= ((cosc_q == `PSC_SRC_SECONDARY_OSC) && sys_run) ||
				osc_q[`PSC_OSC_SOSCEN];
			fail_safe_clock_monitor_en_out <= sys_run;
			osc_tune_out             <= tun_q[5:0];
			watchdog_timer_en_out    <= wdt_q[`PSC_WDT_ON];
			// Only a software write clears the watchdog, never Sleep entry
			watchdog_timer_clear_out <= wdt_clr_d;
			sw_reset_req_out         <= swrst_d;
			power_state_out          <= pst_q;
		end
	end

endmodule

// File: hw/psc_defs.vh
`ifndef PSC_DEFS_VH
`define PSC_DEFS_VH

// ----------------------------------------------------------------
// Register byte offsets
// ----------------------------------------------------------------
`define PSC_WDT_OFS      16'h0000
`define PSC_OSC_OFS      16'hF000
`define PSC_TUN_OFS      16'hF010
`define PSC_KEY_OFS      16'hF230
`define PSC_RCN_OFS      16'hF600
`define PSC_SWR_OFS      16'hF610

// ----------------------------------------------------------------
// Alias codes carried in paddr[3:2]
// ----------------------------------------------------------------
`define PSC_AL_DIR       2'h0
`define PSC_AL_CLR       2'h1
`define PSC_AL_SET       2'h2
`define PSC_AL_INV       2'h3

// ----------------------------------------------------------------
// Oscillator control fields
// ----------------------------------------------------------------
`define PSC_OSC_OSWEN    0
`define PSC_OSC_SOSCEN   1
`define PSC_OSC_CF       3
`define PSC_OSC_SLEEP_SELECT_BIT    4
`define PSC_OSC_SLOCK    5
`define PSC_OSC_CLKLOCK  7
`define PSC_OSC_NOSC     8
`define PSC_OSC_COSC     12
`define PSC_OSC_PBDIV    19
`define PSC_OSC_SOSCRDY  22
`define PSC_OSC_FRCDIV   24
`define PSC_OSC_WMASK    32'h3F1F079F
`define PSC_OSC_PROT     32'h00000701

// ----------------------------------------------------------------
// Other register fields and masks
// ----------------------------------------------------------------
`define PSC_WDT_ON       15
`define PSC_WDT_PS       2
`define PSC_WDT_CLR      0
`define PSC_WDT_WMASK    32'h00008001
`define PSC_TUN_WMASK    32'h0000003F
`define PSC_RCN_POR      0
`define PSC_RCN_BOR      1
`define PSC_RCN_IDLE     2
`define PSC_RCN_SLEEP    3
`define PSC_RCN_WDTO     4
`define PSC_RCN_SWR      6
`define PSC_RCN_EXTR     7
`define PSC_RCN_CMR      9
`define PSC_RCN_WMASK    32'h000003DF
`define PSC_SWR_WMASK    32'h00000001
`define PSC_RST_VALUE    32'h00000000

// ----------------------------------------------------------------
// Clock source codes and configuration word fields
// ----------------------------------------------------------------
`define PSC_SRC_FRC      3'h0
`define PSC_SRC_FRCDIV   3'h1
`define PSC_SRC_PRIMARY_OSC     3'h2
`define PSC_SRC_SECONDARY_OSC     3'h3
`define PSC_SRC_LOW_POWER_INTERNAL_RC_OSC     3'h4
`define PSC_CFG_OSC      0
`define PSC_CFG_FRCDIV   3
`define PSC_CFG_PBDIV    6
`define PSC_CFG_SOSCEN   8
`define PSC_CFG_WDTEN    9
`define PSC_CFG_WDTPS    10

`endif

// File: verification/psc_ctrl_props.sv
`timescale 1ns/100ps

module psc_ctrl_props (
	// Clock and reset
	input wire        mclk_in,
	input wire        reset_in,
	// Register bus
	input wire        psel_in,
	input wire        penable_in,
	input wire [15:0] paddr_in,
	input wire        pslverr_out,
	// Power control
	input wire        wait_instr_in,
	input wire        wake_irq_in,
	input wire        cpu_clk_en_out,
	input wire        system_clock_net_run_out,
	input wire        periph_clk_en_out,
	input wire        peripheral_bus_clock_en_out,
	input wire        fail_safe_clock_monitor_en_out,
	input wire [2:0]  sys_src_sel_out,
	input wire [1:0]  power_state_out
);
	default clocking cb @(posedge mclk_in);
	endclocking
	default disable iff (reset_in);

	// ----------------------------------------------------------------
	// Halted state entry and exit, clock gating while halted, source hold and register alias errors
	// ----------------------------------------------------------------
	sequence s_wait;
		power_state_out == 2'h0 && cpu_clk_en_out && wait_instr_in && !wake_irq_in;
	endsequence
	sequence s_halted;
		power_state_out != 2'h0 && !cpu_clk_en_out;
	endsequence
	// The run state holds for one edge while the request crosses the state and output registers
	property p_wait;
		s_wait |-> ##1 cpu_clk_en_out ##1 s_halted;
	endproperty
	property p_wake;
		power_state_out != 2'h0 && wake_irq_in |-> ##[1:2] (power_state_out == 2'h0 && cpu_clk_en_out);
	endproperty
	property p_cpu_off;
		cpu_clk_en_out |-> power_state_out == 2'h0;
	endproperty
	property p_sleep_stop;
		power_state_out == 2'h2 |-> !system_clock_net_run_out && !periph_clk_en_out;
	endproperty
	property p_idle_run;
		power_state_out == 2'h1 |-> system_clock_net_run_out && periph_clk_en_out;
	endproperty
	property p_monitor_off;
		power_state_out == 2'h2 |-> !fail_safe_clock_monitor_en_out;
	endproperty
	property p_bus_clk_off;
		power_state_out == 2'h2 |-> !peripheral_bus_clock_en_out;
	endproperty
	// A halted CPU must never see its clock source swapped underneath it
	property p_src_hold;
		power_state_out != 2'h0 |-> $stable(sys_src_sel_out);
	endproperty
	property p_key_alias;
		psel_in && penable_in && paddr_in[15:4] == 12'hF23 && paddr_in[3:2] != 2'h0 |-> pslverr_out;
	endproperty
	property p_tune_alias;
		psel_in && penable_in && paddr_in[15:4] == 12'hF01 && paddr_in[1:0] == 2'h0 |-> !pslverr_out;
	endproperty

	a_wait: assert property (p_wait) else $error("wait did not halt the cpu");
	a_wake: assert property (p_wake) else $error("interrupt did not wake");
	a_cpu_off: assert property (p_cpu_off) else $error("cpu clock on while halted");
	a_sleep_stop: assert property (p_sleep_stop) else $error("clock runs in sleep");
	a_idle_run: assert property (p_idle_run) else $error("clock stopped in idle");
	a_monitor_off: assert property (p_monitor_off) else $error("monitor on in sleep");
	a_bus_clk_off: assert property (p_bus_clk_off) else $error("bus clock in sleep");
	a_src_hold: assert property (p_src_hold) else $error("source changed while halted");
	a_key_alias: assert property (p_key_alias) else $error("key alias accepted");
	a_tune_alias: assert property (p_tune_alias) else $error("alias refused");
endmodule

bind psc_ctrl psc_ctrl_props psc_ctrl_props_i (.*);

// File: verification/tb_top.sv
`timescale 1ns/100ps
`include "psc_defs.vh"

module tb_top;
	// ----------------------------------------------------------------
	// Bench signals
	// ----------------------------------------------------------------
	localparam [31:0] K1 = 32'hA5C30F1E; // Arbitrary unlock pair
	localparam [31:0] K2 = 32'h5A3CF0E1;
	reg         mclk_in = 1'b0;
	reg         reset_in = 1'b1;
	reg         psel_in = 1'b0;
	reg         penable_in = 1'b0;
	reg         pwrite_in = 1'b0;
	reg  [15:0] paddr_in = 16'h0000;
	reg  [31:0] pwdata_in = 32'h00000000;
	reg  [15:0] device_config_words_in = 16'h1798;
	reg         por_event_in = 1'b1;
	reg         bor_event_in = 1'b0;
	reg         ext_reset_event_in = 1'b0;
	reg         wdt_timeout_event_in = 1'b0;
	reg         cfg_mismatch_in = 1'b0;
	reg         wait_instr_in = 1'b0;
	reg         wake_irq_in = 1'b0;
	reg         secondary_osc_ready_in = 1'b0;
	reg         pll_lock_in = 1'b0;
	reg         clk_fail_in = 1'b0;
	wire [31:0] prdata_out;
	wire        pready_out, pslverr_out, cpu_clk_en_out, system_clock_net_run_out;
	wire        periph_clk_en_out, peripheral_bus_clock_en_out, primary_osc_en_out;
	wire        fast_internal_rc_osc_en_out, low_power_internal_rc_osc_en_out, secondary_osc_en_out;
	wire        fail_safe_clock_monitor_en_out, watchdog_timer_en_out, watchdog_timer_clear_out;
	wire        sw_reset_req_out;
	wire [2:0]  sys_src_sel_out, frc_postscale_out;
	wire [5:0]  osc_tune_out;
	wire [1:0]  power_state_out;
	reg  [31:0] rdq;
	reg         erq;
	integer     fails = 0;
	integer     num_checks = 0;
	integer     i;

	psc_ctrl #(.KEY_FIRST(K1), .KEY_SECOND(K2)) psc_ctrl_i (.*);

	// Free-running 250 MHz clock
	initial begin
		forever #2 mclk_in = ~mclk_in;
	end

	// ----------------------------------------------------------------
	// Tasks
	// ----------------------------------------------------------------
	task close_out;
		begin
			$display("checks=%0d mismatches=%0d", num_checks, fails);
			if (fails == 0 && num_checks > 0) begin
				$display("Finished cleanly");
			end else begin
				$display("Finished with errors");
			end
			$finish;
		end
	endtask

	task chk(input [31:0] seen, input [31:0] exp);
		begin
			num_checks = num_checks + 1;
			if (seen !== exp) begin
				fails = fails + 1;
				$display("FAIL t=%0t seen=%h exp=%h", $time, seen, exp);
			end
		end
	endtask

	// One APB transfer; read data and error are taken at the pready edge only
	task apb(input w, input [15:0] a, input [31:0] d);
		begin
			@(posedge mclk_in);
			psel_in <= 1'b1;
			pwrite_in <= w;
			paddr_in <= a;
			pwdata_in <= d;
			@(posedge mclk_in);
			penable_in <= 1'b1;
			@(posedge mclk_in);
			while (pready_out !== 1'b1) begin
				@(posedge mclk_in);
			end
			rdq = prdata_out;
			erq = pslverr_out;
			psel_in <= 1'b0;
			penable_in <= 1'b0;
		end
	endtask

	task rdc(input [15:0] a, input [31:0] m, input [31:0] e);
		begin
			apb(1'b0, a, 32'h00000000);
			chk(rdq & m, e);
		end
	endtask

	// Spacing between two bus clock enable pulses
	task gap(input integer exp);
		integer k;
		begin
			// Let a divider change settle so the old count cannot shorten a gap
			repeat (8) @(posedge mclk_in);
			k = 0;
			while (peripheral_bus_clock_en_out !== 1'b1 && k < 40) begin
				@(posedge mclk_in);
				k = k + 1;
			end
			@(posedge mclk_in);
			k = 1;
			while (peripheral_bus_clock_en_out !== 1'b1 && k < 40) begin
				@(posedge mclk_in);
				k = k + 1;
			end
			chk(k, exp);
		end
	endtask

	// Clock switch; the core accepts it only while unlocked
	task sw(input [2:0] s);
		integer k;
		begin
			apb(1'b1, `PSC_OSC_OFS + 16'h4, 32'h00000700);
			apb(1'b1, `PSC_OSC_OFS + 16'h8, {21'h0, s, 8'h01});
			k = 0;
			while (sys_src_sel_out !== s && k < 50) begin
				@(posedge mclk_in);
				k = k + 1;
			end
			chk(sys_src_sel_out, s);
			rdc(`PSC_OSC_OFS, 32'h00007001, {17'h0, s, 12'h000});
			if (s == 3'h1) begin
				chk(frc_postscale_out, 32'h3);
			end
		end
	endtask

	// Wait with the sleep bit chosen, look at the halted state, then wake
	task pm(input s, input [2:0] src);
		begin
			apb(1'b1, s ? `PSC_OSC_OFS + 16'h8 : `PSC_OSC_OFS + 16'h4, 32'h00000010);
			@(posedge mclk_in);
			wait_instr_in <= 1'b1;
			@(posedge mclk_in);
			wait_instr_in <= 1'b0;
			repeat (3) @(posedge mclk_in);
			chk(power_state_out, s ? 32'h2 : 32'h1);
			chk(cpu_clk_en_out, 32'h0);
			chk(system_clock_net_run_out, !s);
			chk(periph_clk_en_out, !s);
			chk(fail_safe_clock_monitor_en_out, !s);
			chk(sys_src_sel_out, src);
			chk(watchdog_timer_en_out, 32'h1);
			chk(watchdog_timer_clear_out, 32'h0);
			chk(primary_osc_en_out, src == 3'h2);
			chk(fast_internal_rc_osc_en_out, src < 3'h2);
			chk(frc_postscale_out, (src == 3'h1) ? 32'h3 : 32'h0);
			chk(low_power_internal_rc_osc_en_out, 32'h1);
			chk(secondary_osc_en_out, 32'h1);
			wake_irq_in <= 1'b1;
			repeat (4) @(posedge mclk_in);
			wake_irq_in <= 1'b0;
			chk(cpu_clk_en_out, 32'h1);
			rdc(`PSC_RCN_OFS, s ? 32'h8 : 32'h4, s ? 32'h8 : 32'h4);
		end
	endtask

	// Cut a hang short well past the expected run length
	initial begin
		#80000;
		fails = fails + 1;
		close_out;
	end

	// ----------------------------------------------------------------
	// Test sequence
	// ----------------------------------------------------------------
	initial begin
		repeat (6) @(posedge mclk_in);
		reset_in <= 1'b0;
		repeat (2) @(posedge mclk_in);
		chk(pready_out, 32'h1);
		rdc(`PSC_WDT_OFS, 32'hFFFFFFFF, 32'h00008014);
		rdc(`PSC_OSC_OFS, 32'h07187002, 32'h03100002);
		rdc(`PSC_RCN_OFS, 32'hFFFFFFFF, 32'h00000001);
		rdc(`PSC_TUN_OFS, 32'hFFFFFFFF, 32'h00000000);
		rdc(`PSC_KEY_OFS, 32'hFFFFFFFF, 32'h00000000);
		gap(4);
		apb(1'b1, `PSC_TUN_OFS, 32'hFFFFFFFF);
		rdc(`PSC_TUN_OFS, 32'hFFFFFFFF, 32'h0000003F);
		apb(1'b1, `PSC_TUN_OFS + 16'h4, 32'h0000000F);
		apb(1'b1, `PSC_TUN_OFS + 16'h8, 32'h00000001);
		rdc(`PSC_TUN_OFS, 32'hFFFFFFFF, 32'h00000031);
		apb(1'b1, `PSC_TUN_OFS + 16'hC, 32'h0000003F);
		rdc(`PSC_TUN_OFS, 32'hFFFFFFFF, 32'h0000000E);
		chk(osc_tune_out, 32'h0E);
		apb(1'b1, `PSC_KEY_OFS + 16'h4, K1);
		chk(erq, 32'h1);
		apb(1'b0, 16'h1000, 32'h00000000);
		chk({erq, rdq[30:0]}, 32'h80000000);
		// Still locked, so the switch request must be dropped
		apb(1'b1, `PSC_OSC_OFS + 16'h8, 32'h00000401);
		rdc(`PSC_OSC_OFS, 32'h00007701, 32'h00000000);
		for (i = 0; i < 4; i = i + 1) begin
			apb(1'b1, `PSC_OSC_OFS + 16'h4, 32'h00180000);
			apb(1'b1, `PSC_OSC_OFS + 16'h8, i << 19);
			gap(1 << i);
		end
		pm(1'b0, 3'h0);
		apb(1'b1, `PSC_KEY_OFS, K1);
		apb(1'b1, `PSC_KEY_OFS, K2);
		secondary_osc_ready_in <= 1'b1;
		for (i = 1; i < 5; i = i + 1) begin
			sw(i[2:0]);
			pm(1'b0, i[2:0]);
		end
		pm(1'b1, 3'h4);
		clk_fail_in <= 1'b1;
		pll_lock_in <= 1'b1;
		// The clear lands while the failure still stands, so the flag must stay
		apb(1'b1, `PSC_OSC_OFS + 16'h4, 32'h00000008);
		rdc(`PSC_OSC_OFS, 32'h00400028, 32'h00400028);
		apb(1'b1, `PSC_WDT_OFS, 32'h00008001);
		@(posedge mclk_in);
		chk(watchdog_timer_clear_out, 32'h1);
		rdc(`PSC_WDT_OFS, 32'hFFFFFFFF, 32'h00008014);
		apb(1'b1, `PSC_SWR_OFS, 32'h00000001);
		apb(1'b0, `PSC_SWR_OFS, 32'h00000000);
		// Reset in mid-run on the trigger pulse, every other cause but power-on raised too
		reset_in <= 1'b1;
		por_event_in <= 1'b0;
		bor_event_in <= 1'b1;
		ext_reset_event_in <= 1'b1;
		wdt_timeout_event_in <= 1'b1;
		cfg_mismatch_in <= 1'b1;
		device_config_words_in <= 16'h179C;
		@(posedge mclk_in);
		chk(sw_reset_req_out, 32'h1);
		@(posedge mclk_in);
		reset_in <= 1'b0;
		repeat (3) @(posedge mclk_in);
		chk(sys_src_sel_out, 32'h4);
		rdc(`PSC_RCN_OFS, 32'hFFFFFFFF, 32'h000002DF);
		close_out;
	end
endmodule
